// *** hdl/srh_host.v ***
// Host controller that writes and reads the inverting 16x4 static memory
`timescale 1ns/1ps
`include "srh_defines.vh"
module srh_host #(
    parameter AW          = 4,
    parameter DW          = 4,
    parameter SETUP_CYC   = `SRH_CYC(`SRH_T_SETUP_A_NS),
    parameter WPULSE_CYC  = `SRH_CYC(`SRH_T_WPULSE_NS),
    parameter HOLD_CYC    = `SRH_CYC(`SRH_T_HOLD_A_NS),
    parameter ACCESS_CYC  = `SRH_CYC(`SRH_T_ACCESS_NS),
    parameter RECOV_CYC   = `SRH_CYC(`SRH_T_RECOV_NS),
    parameter DESEL_CYC   = `SRH_CYC(`SRH_T_DESEL_NS)
) (
    // Clock and reset
    input  wire          ref_clk,
    input  wire          rst,
    // User request
    input  wire          req_valid,
    input  wire          req_write,
    input  wire [AW-1:0] req_addr,
    input  wire [DW-1:0] req_wdata,
    output reg           req_ready_r,
    // User answer
    output reg           rsp_valid_r,
    output reg  [DW-1:0] rsp_rdata_r,
    // Memory pins
    output reg  [AW-1:0] word_address_r,
    output reg  [DW-1:0] write_data_in_r,
    output reg           chip_sel_n_r,
    output reg           write_en_n_r,
    input  wire [DW-1:0] read_data_out_inverted
);
    // One access runs at a time. A request seen while the sequencer is busy is
    // not stored, so the user keeps req_valid up until req_ready_r returns.
    // All waits are whole clock cycles rounded up from the memory timing, never fewer than one.
    // Writes and reads leave the memory deselected for a gap before the next access.

    // Sequencer states, binary coded
    localparam [2:0] ST_IDLE  = 3'h0;   // Waiting for a request
    localparam [2:0] ST_SETUP = 3'h1;   // Address settling before the strobe
    localparam [2:0] ST_WLOW  = 3'h2;   // Write strobe held low
    localparam [2:0] ST_HOLD  = 3'h3;   // Address hold and write recovery
    localparam [2:0] ST_RWAIT = 3'h4;   // Waiting out the access delay
    localparam [2:0] ST_DESEL = 3'h5;   // Deselect gap before the next access

    // Every timing parameter must lie between 1 and 255: the loads below are
    // one less than the count and the counter is eight bits wide.
    localparam [7:0] SETUP_LD  = SETUP_CYC[7:0] - 8'h01;
    localparam [7:0] WPULSE_LD = WPULSE_CYC[7:0] - 8'h01;
    localparam [7:0] ACCESS_LD = ACCESS_CYC[7:0] - 8'h01;
    localparam [7:0] DESEL_LD  = DESEL_CYC[7:0] - 8'h01;
    // Hold and recovery run side by side, so the longer one sets the wait
    localparam [7:0] RECOV_LD  = (HOLD_CYC > RECOV_CYC) ? HOLD_CYC[7:0] - 8'h01
                                                        : RECOV_CYC[7:0] - 8'h01;

    // Sequencer state and cycle counter
    reg  [2:0]    state_r;
    reg  [2:0]    state_nxt;
    reg  [7:0]    cnt_r;
    reg  [7:0]    cnt_nxt;
    // Kind of the access in progress
    reg           is_write_r;
    reg           is_write_nxt;
    // Next values of the registered outputs
    reg           req_ready_nxt;
    reg           rsp_valid_nxt;
    reg  [DW-1:0] rsp_rdata_nxt;
    reg  [AW-1:0] word_address_nxt;
    reg  [DW-1:0] write_data_in_nxt;
    reg           chip_sel_n_nxt;
    reg           write_en_n_nxt;
    // Events decoded in the current cycle
    wire          cnt_done;
    wire          take_req;
    wire          read_done;
    wire          write_done;
    // Memory word in true polarity
    wire [DW-1:0] rd_true;

    // Counter expiry and the cycles where an access starts or ends
    // The counter is zero whenever the sequencer sits idle
    assign cnt_done   = (cnt_r == 8'h00);
    assign take_req   = (state_r == ST_IDLE) && cnt_done && req_valid;
    assign read_done  = (state_r == ST_RWAIT) && cnt_done;
    assign write_done = (state_r == ST_HOLD) && cnt_done;

    // Undo the output inversion of the memory bit by bit
    genvar bit_i;
    generate
        for (bit_i = 0; bit_i < DW; bit_i = bit_i + 1) begin : g_rd_bit
            assign rd_true[bit_i] = ~read_data_out_inverted[bit_i];
        end
    endgenerate

    // Next state and counter; the counter runs down before a state moves on
    always @* begin
        state_nxt = state_r;
        cnt_nxt   = cnt_r;
        if (!cnt_done) begin
            cnt_nxt = cnt_r - 8'h01;
        end else begin
            case (state_r)
                ST_IDLE: begin
                    if (req_valid) begin
                        state_nxt = ST_SETUP;
                        cnt_nxt   = SETUP_LD;
                    end
                end
                ST_SETUP: begin
                    if (is_write_r) begin
                        state_nxt = ST_WLOW;
                        cnt_nxt   = WPULSE_LD;
                    end else begin
                        state_nxt = ST_RWAIT;
                        cnt_nxt   = ACCESS_LD;
                    end
                end
                ST_WLOW: begin
                    state_nxt = ST_HOLD;
                    cnt_nxt   = RECOV_LD;
                end
                ST_HOLD: begin
                    state_nxt = ST_DESEL;
                    cnt_nxt   = DESEL_LD;
                end
                ST_RWAIT: begin
                    state_nxt = ST_DESEL;
                    cnt_nxt   = DESEL_LD;
                end
                ST_DESEL: begin
                    state_nxt = ST_IDLE;
                end
                default: begin
                    state_nxt = ST_IDLE;
                end
            endcase
        end
    end

    // Kind, address and data are captured when a request is taken, then held
    always @* begin
        is_write_nxt      = is_write_r;
        word_address_nxt  = word_address_r;
        write_data_in_nxt = write_data_in_r;
        if (take_req) begin
            is_write_nxt      = req_write;
            word_address_nxt  = req_addr;
            write_data_in_nxt = req_wdata;
        end
    end

    // Chip select falls with the new address and rises once the access is over
    always @* begin
        chip_sel_n_nxt = chip_sel_n_r;
        if (take_req) begin
            chip_sel_n_nxt = 1'b0;
        end else if (read_done || write_done) begin
            chip_sel_n_nxt = 1'b1;
        end
    end

    // Write strobe low only in the pulse state, which lies inside the selected span
    always @* begin
        write_en_n_nxt = (state_nxt == ST_WLOW) ? 1'b0 : 1'b1;
    end

    // Answer pulse and word; a write answers with the readback after recovery
    always @* begin
        rsp_valid_nxt = 1'b0;
        rsp_rdata_nxt = rsp_rdata_r;
        if (read_done || write_done) begin
            rsp_valid_nxt = 1'b1;
            rsp_rdata_nxt = rd_true;
        end
    end

    // Ready only while the sequencer stays idle
    always @* begin
        req_ready_nxt = (state_nxt == ST_IDLE) ? 1'b1 : 1'b0;
    end

    // Sequencer registers
    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            state_r    <= ST_IDLE;
            cnt_r      <= 8'h00;
            is_write_r <= 1'b0;
        end else begin
            state_r    <= state_nxt;
            cnt_r      <= cnt_nxt;
            is_write_r <= is_write_nxt;
        end
    end

    // Memory pins come straight from flip-flops so no glitch reaches the strobes
    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            word_address_r  <= {AW{1'b0}};
            write_data_in_r <= {DW{1'b0}};
            chip_sel_n_r    <= `SRH_RST_SEL_N;
            write_en_n_r    <= `SRH_RST_WE_N;
        end else begin
            word_address_r  <= word_address_nxt;
            write_data_in_r <= write_data_in_nxt;
            chip_sel_n_r    <= chip_sel_n_nxt;
            write_en_n_r    <= write_en_n_nxt;
        end
    end

    // User handshake registers
    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            req_ready_r <= `SRH_RST_READY;
            rsp_valid_r <= 1'b0;
            rsp_rdata_r <= {DW{1'b0}};
        end else begin
            req_ready_r <= req_ready_nxt;
            rsp_valid_r <= rsp_valid_nxt;
            rsp_rdata_r <= rsp_rdata_nxt;
        end
    end
endmodule // srh_host

// *** hdl/srh_defines.vh ***
// Constants for the inverting 16x4 static memory host controller
`ifndef SRH_DEFINES_VH
`define SRH_DEFINES_VH
`define SRH_CLK_PERIOD_NS 10
`define SRH_T_SETUP_A_NS  0
`define SRH_T_HOLD_A_NS   0
`define SRH_T_WPULSE_NS   25
`define SRH_T_ACCESS_NS   50
`define SRH_T_RECOV_NS    40
`define SRH_T_DESEL_NS    25
`define SRH_CYC(ns) ((((ns) + `SRH_CLK_PERIOD_NS - 1) / `SRH_CLK_PERIOD_NS) < 1 ? \
    1 : (((ns) + `SRH_CLK_PERIOD_NS - 1) / `SRH_CLK_PERIOD_NS))
`define SRH_RST_SEL_N 1'b1
`define SRH_RST_WE_N  1'b1
`define SRH_RST_READY 1'b0
`endif

// *** dv/srh_mem.sv ***
// Behavioural inverting 16x4 memory with open-collector or three-state outputs
`timescale 1ns/1ps
module srh_mem #(
    parameter OPEN_COLLECTOR = 1
) (
    // Memory pins
    input  wire [3:0] word_address,
    input  wire [3:0] write_data_in,
    input  wire       chip_sel_n,
    input  wire       write_en_n,
    output wire [3:0] read_data_out_inverted
);
    reg  [3:0] mem_r [0:15];
    wire [3:0] idle_lvl;
    // Disabled level: released high, or floating on three-state parts
    assign idle_lvl = OPEN_COLLECTOR ? 4'hf : 4'hz;
    // Word taken as the strobe ends while selected, kept otherwise
    always @(posedge write_en_n) begin
        if (!chip_sel_n) mem_r[word_address] <= write_data_in;
    end
    // Inverted word when reading, disabled level while writing or deselected
    assign read_data_out_inverted = (!chip_sel_n && write_en_n) ? ~mem_r[word_address] :
        idle_lvl;
endmodule // srh_mem

// *** dv/srh_host_asserts.sv ***
// Checker for the host write sequencing on the memory pins
`timescale 1ns/1ps
module srh_host_asserts (
    // Clock, reset and pins
    input wire       ref_clk,
    input wire       rst,
    input wire [3:0] word_address_r,
    input wire       chip_sel_n_r,
    input wire       write_en_n_r
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    sequence strobe_s; !write_en_n_r [*3] ##1 write_en_n_r; endsequence
    sequence hold_s; $stable(word_address_r) [*2]; endsequence
    addr_setup_a: assert property ($fell(write_en_n_r) |->
        $stable(word_address_r) && !$past(chip_sel_n_r)) else $error("address setup");
    strobe_len_a: assert property ($fell(write_en_n_r) |-> strobe_s)
        else $error("strobe");
    write_sel_a: assert property (!write_en_n_r |-> !chip_sel_n_r)
        else $error("select");
    addr_hold_a: assert property ($rose(write_en_n_r) |-> hold_s)
        else $error("hold");
endmodule // srh_host_asserts
bind srh_host srh_host_asserts chk_u (.ref_clk(ref_clk), .rst(rst),
    .word_address_r(word_address_r), .chip_sel_n_r(chip_sel_n_r),
    .write_en_n_r(write_en_n_r));

// *** dv/srh_host_bench.sv ***
// Self-checking bench for the inverting memory host
`timescale 1ns/1ps
`define SRH_CHK(nm, e, g) begin n_tests = n_tests + 1; if ((g) !== (e)) begin \
    bad_count = bad_count + 1; $display("[FAIL] %s exp %h got %h", nm, e, g); end end
module srh_host_bench;
    reg        ref_clk = 1'b0, rst = 1'b1, req_valid = 1'b0, req_write = 1'b0;
    reg  [3:0] req_addr = 4'h0, req_wdata = 4'h0, model [0:15];
    reg  [31:0] rnd;
    wire       req_ready_r, rsp_valid_r, chip_sel_n_r, write_en_n_r;
    wire [3:0] rsp_rdata_r, word_address_r, write_data_in_r, read_data_out_inverted;
    integer    bad_count = 0, n_tests = 0, cyc = 0, i, k;
    // Clock
    always #5 ref_clk = ~ref_clk;
    srh_host dut_u (.ref_clk(ref_clk), .rst(rst), .req_valid(req_valid), .req_write(req_write),
        .req_addr(req_addr), .req_wdata(req_wdata), .req_ready_r(req_ready_r),
        .rsp_valid_r(rsp_valid_r), .rsp_rdata_r(rsp_rdata_r), .word_address_r(word_address_r),
        .write_data_in_r(write_data_in_r), .chip_sel_n_r(chip_sel_n_r),
        .write_en_n_r(write_en_n_r), .read_data_out_inverted(read_data_out_inverted));
    srh_mem mem_u (.word_address(word_address_r), .write_data_in(write_data_in_r),
        .chip_sel_n(chip_sel_n_r), .write_en_n(write_en_n_r),
        .read_data_out_inverted(read_data_out_inverted));
    // Verdict and end of run
    task finish_test;
        begin
            if (bad_count == 0 && n_tests > 0) $display("TEST PASSED");
            else $display("TEST FAILED");
            $finish;
        end
    endtask
    // Cycle ceiling: 72 accesses of at most 12 cycles each, with ample margin
    always @(posedge ref_clk) begin
        cyc = cyc + 1;
        if (cyc == 3000) begin
            bad_count = bad_count + 1;
            finish_test;
        end
    end
    // One request, then compare the answer with the model
    task access(input reg w, input reg [3:0] a, input reg [3:0] d);
        begin
            while (req_ready_r !== 1'b1) @(negedge ref_clk);
            req_valid = 1'b1;
            req_write = w;
            req_addr = a;
            req_wdata = d;
            @(negedge ref_clk);
            req_valid = 1'b0;
            for (k = 0; k < 20 && rsp_valid_r !== 1'b1; k = k + 1) @(negedge ref_clk);
            if (w) model[a] = d;
            `SRH_CHK("answer", 1'b1, rsp_valid_r)
            `SRH_CHK("word", model[a], rsp_rdata_r)
            `SRH_CHK("address", a, word_address_r)
            if (w) `SRH_CHK("data", d, write_data_in_r)
            `SRH_CHK("strobe", 1'b1, write_en_n_r)
            `SRH_CHK("deselect", 1'b1, chip_sel_n_r)
        end
    endtask
    // Fill every word, read every word, then random traffic
    initial begin
        k = $urandom(34876);
        repeat (5) @(negedge ref_clk);
        rst = 1'b0;
        for (i = 0; i < 16; i = i + 1) access(1'b1, i[3:0], i[3:0] ^ 4'h5);
        for (i = 0; i < 16; i = i + 1) access(1'b0, i[3:0], 4'h0);
        for (i = 0; i < 40; i = i + 1) begin
            rnd = $urandom;
            access(rnd[8], rnd[7:4], rnd[3:0]);
        end
        finish_test;
    end
endmodule // srh_host_bench
